// file: core/pec_pkg.sv
// Shared constants for the protection element comparator.
// Assumes a 125 MHz system clock and an AHB-Lite register bus.
package pec_pkg;
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int MEM_AW = 5;
    localparam int BASE_W = 16;
    localparam int PU_FRAC = 16;
    localparam int THR_W = DW + BASE_W;
    localparam int EVW = 3;

    // Register byte offsets
    localparam logic [AW-1:0] A_CTRL     = 8'h00;
    localparam logic [AW-1:0] A_GROUP    = 8'h04;
    localparam logic [AW-1:0] A_STATUS   = 8'h08;
    localparam logic [AW-1:0] A_INT_STAT = 8'h0c;
    localparam logic [AW-1:0] A_INT_CLR  = 8'h10;
    localparam logic [AW-1:0] A_INT_EN   = 8'h14;
    localparam logic [AW-1:0] A_TGT_RST  = 8'h18;
    localparam logic [AW-1:0] A_TICK_DIV = 8'h1c;
    localparam logic [AW-1:0] A_BASE     = 8'h20;
    localparam int A_SET_BIT = 7;

    // Control register fields
    localparam int CTRL_FUNC    = 0;
    localparam int CTRL_BLOCK   = 1;
    localparam int CTRL_EVT     = 2;
    localparam int CTRL_GROUPED = 3;
    localparam int CTRL_TGT_LSB = 4;
    localparam int CTRL_W       = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

    // Target modes
    localparam logic [1:0] TARGET_DISABLED    = 2'h0;
    localparam logic [1:0] TARGET_FOLLOW_MODE = 2'h1;
    localparam logic [1:0] TARGET_LATCHED     = 2'h2;

    // Setting set layout: word index is {set, item}
    localparam logic [1:0] ITEM_PK_LO  = 2'h0;
    localparam logic [1:0] ITEM_PK_HI  = 2'h1;
    localparam logic [1:0] ITEM_PK_DLY = 2'h2;
    localparam logic [1:0] ITEM_RS_DLY = 2'h3;
    localparam logic [2:0] NUM_GROUPS  = 3'h6;
    localparam logic [2:0] CONTROL_SET = 3'h6;
    localparam logic [2:0] GROUP_RST   = 3'h0;

    // Status and event bit positions
    localparam int ST_PICKUP_BIT  = 0;
    localparam int ST_OPERATE_BIT = 1;
    localparam int ST_TARGET_BIT  = 2;
    localparam int ST_RUN_BIT     = 3;
    localparam int EV_PICKUP      = 0;
    localparam int EV_DROPOUT     = 1;
    localparam int EV_OPERATE     = 2;

    // Timebase: one tick per microsecond by default
    localparam int CLK_PERIOD_NS  = 8;
    localparam int TICK_PERIOD_NS = 1000;
    localparam logic [DW-1:0] TICK_DIV_RST = DW'(TICK_PERIOD_NS / CLK_PERIOD_NS - 1);
    localparam logic [DW-1:0] BASE_RST     = 32'h00010001;

    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {ST_IDLE, ST_PICKUP, ST_OPERATE, ST_RESETTING} pec_state_t;
endpackage

// file: core/pec_tmr_if.sv
// Handshake between the element sequencer and its delay timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface pec_tmr_if;
    logic                     start;
    logic [pec_pkg::DW-1:0]   load;
    logic                     tick;
    logic                     done;
    modport ctl (output start, output load, output tick, input done);
    modport tmr (input start, input load, input tick, output done);
endinterface

// file: core/pec_delay_timer.sv
// Tick-driven down counter for pickup and reset delays.
// Assumes load is at least one tick; zero delays never start it.
`timescale 1ns/1ps
module pec_delay_timer
    import pec_pkg::*;
(
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    // Control
    pec_tmr_if.tmr    tmr
);
    logic [DW-1:0] count_reg;
    logic [DW-1:0] count_next;
    logic          run_reg;
    logic          run_next;
    logic          done_reg;
    logic          done_next;

    always_comb begin
        count_next = count_reg;
        run_next   = run_reg;
        done_next  = 1'b0;
        if (tmr.start) begin
            count_next = tmr.load;
            run_next   = 1'b1;
        end else if (run_reg && tmr.tick) begin
            if (count_reg <= DW'(1)) begin
                run_next  = 1'b0;
                done_next = 1'b1;
            end else begin
                count_next = count_reg - DW'(1);
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            count_reg <= '0;
            run_reg   <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg   <= run_next;
            done_reg  <= done_next;
        end
    end

    assign tmr.done = done_reg;
endmodule

// file: core/pec_set_mem.sv
// Setting store: 32 words, six group sets, one control set and one spare set, four words each.
// Both read ports return data one cycle after the address.
`timescale 1ns/1ps
module pec_set_mem
    import pec_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    // Write port
    input  wire logic              wr_en_in,
    input  wire logic [MEM_AW-1:0] wr_addr_in,
    input  wire logic [DW-1:0]     wr_data_in,
    // Read ports
    input  wire logic [MEM_AW-1:0] a_addr_in,
    output logic      [DW-1:0]     a_data_out,
    input  wire logic [MEM_AW-1:0] b_addr_in,
    output logic      [DW-1:0]     b_data_out
);
    localparam int DEPTH = 1 << MEM_AW;

    logic [DW-1:0] word_reg [DEPTH];

    for (genvar gi = 0; gi < DEPTH; gi++) begin : g_word
        always_ff @(posedge mclk_in) begin
            if (!rst_n_in) begin
                word_reg[gi] <= '0;
            end else if (wr_en_in && wr_addr_in == MEM_AW'(gi)) begin
                word_reg[gi] <= wr_data_in;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            a_data_out <= '0;
            b_data_out <= '0;
        end else begin
            a_data_out <= word_reg[a_addr_in];
            b_data_out <= word_reg[b_addr_in];
        end
    end
endmodule

// file: core/pec_top.sv
// Protection element comparator with AHB-Lite register slave.
// Assumes meas_in, run_in, block_in come from logic on mclk_in.
`timescale 1ns/1ps
module pec_top
    import pec_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk_in,
    input  wire logic          rst_n_in,
    // AHB-Lite slave
    input  wire logic          hsel_in,
    input  wire logic [31:0]   haddr_in,
    input  wire logic [1:0]    htrans_in,
    input  wire logic          hwrite_in,
    input  wire logic [2:0]    hsize_in,
    input  wire logic [DW-1:0] hwdata_in,
    input  wire logic          hready_in,
    output logic               hreadyout_out,
    output logic               hresp_out,
    output logic      [DW-1:0] hrdata_out,
    // Element inputs
    input  wire logic [DW-1:0] meas_in,
    input  wire logic          run_in,
    input  wire logic          block_in,
    // Element outputs
    output logic               pickup_out,
    output logic               operate_out,
    output logic               target_out,
    output logic               pickup_event_out,
    output logic               dropout_event_out,
    output logic               operate_event_out,
    output logic               irq_out
);
    // Bus state
    logic [AW-1:0]     addr_reg;
    logic [AW-1:0]     addr_next;
    logic              wr_ph_reg;
    logic              wr_ph_next;
    logic              rd1_reg;
    logic              rd1_next;
    logic              rd2_reg;
    logic              rd2_next;
    logic              hready_reg;
    logic              hready_next;
    logic [DW-1:0]     hrdata_reg;
    logic [DW-1:0]     hrdata_next;
    logic              accept;
    logic              wr_cycle;

    // Software registers
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] ctrl_next;
    logic [2:0]        group_reg;
    logic [2:0]        group_next;
    logic [EVW-1:0]    int_en_reg;
    logic [EVW-1:0]    int_en_next;
    logic [EVW-1:0]    int_stat_reg;
    logic [EVW-1:0]    int_stat_next;
    logic [DW-1:0]     tick_div_reg;
    logic [DW-1:0]     tick_div_next;
    logic [DW-1:0]     base_reg;
    logic [DW-1:0]     base_next;
    logic [EVW-1:0]    int_clr;
    logic              tgt_rst;
    logic              mem_wr;

    // Setting shadow and scan
    logic [1:0]        scan_reg;
    logic [1:0]        scan_next;
    logic [1:0]        scan_d_reg;
    logic [DW-1:0]     pk_lo_reg;
    logic [DW-1:0]     pk_lo_next;
    logic [DW-1:0]     pk_hi_reg;
    logic [DW-1:0]     pk_hi_next;
    logic [DW-1:0]     pk_dly_reg;
    logic [DW-1:0]     pk_dly_next;
    logic [DW-1:0]     rs_dly_reg;
    logic [DW-1:0]     rs_dly_next;
    logic [THR_W-1:0]  thr_lo_reg;
    logic [THR_W-1:0]  thr_lo_next;
    logic [THR_W-1:0]  thr_hi_reg;
    logic [THR_W-1:0]  thr_hi_next;
    logic [2:0]        act_set;
    logic [DW-1:0]     mem_a_data;
    logic [DW-1:0]     mem_b_data;

    // Element state
    pec_state_t        state_reg;
    pec_state_t        state_next;
    logic              pickup_reg;
    logic              operate_reg;
    logic              operate_next;
    logic              target_reg;
    logic              target_next;
    logic [EVW-1:0]    ev_reg;
    logic [EVW-1:0]    ev_next;
    logic              irq_reg;
    logic              irq_next;
    logic [DW-1:0]     tick_cnt_reg;
    logic [DW-1:0]     tick_cnt_next;
    logic              tick_reg;
    logic              tick_next;
    logic              run;
    logic              pk;
    logic [BASE_W-1:0] base_pu;
    logic [THR_W-1:0]  meas_scaled;

    pec_tmr_if tmr_bus ();

    // Bus address and data phase tracking
    assign accept   = hsel_in && htrans_in[HTRANS_ACTIVE_BIT] && hready_in;
    assign wr_cycle = wr_ph_reg;

    always_comb begin
        addr_next   = addr_reg;
        wr_ph_next  = 1'b0;
        rd1_next    = 1'b0;
        rd2_next    = rd1_reg;
        hready_next = hready_reg;
        hrdata_next = hrdata_reg;
        if (accept) begin
            addr_next   = haddr_in[AW-1:0];
            wr_ph_next  = hwrite_in;
            rd1_next    = !hwrite_in;
            hready_next = hwrite_in;
        end
        if (rd2_reg) begin
            hready_next = 1'b1;
            hrdata_next = '0;
            if (addr_reg[A_SET_BIT]) begin
                hrdata_next = mem_a_data;
            end else begin
                case (addr_reg)
                    A_CTRL:     hrdata_next = DW'(ctrl_reg);
                    A_GROUP:    hrdata_next = DW'(group_reg);
                    A_STATUS: begin
                        hrdata_next[ST_PICKUP_BIT]  = pickup_reg;
                        hrdata_next[ST_OPERATE_BIT] = operate_reg;
                        hrdata_next[ST_TARGET_BIT]  = target_reg;
                        hrdata_next[ST_RUN_BIT]     = run;
                    end
                    A_INT_STAT: hrdata_next = DW'(int_stat_reg);
                    A_INT_EN:   hrdata_next = DW'(int_en_reg);
                    A_TICK_DIV: hrdata_next = tick_div_reg;
                    A_BASE:     hrdata_next = base_reg;
                    default:    hrdata_next = '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            addr_reg   <= '0;
            wr_ph_reg  <= 1'b0;
            rd1_reg    <= 1'b0;
            rd2_reg    <= 1'b0;
            hready_reg <= 1'b1;
            hrdata_reg <= '0;
        end else begin
            addr_reg   <= addr_next;
            wr_ph_reg  <= wr_ph_next;
            rd1_reg    <= rd1_next;
            rd2_reg    <= rd2_next;
            hready_reg <= hready_next;
            hrdata_reg <= hrdata_next;
        end
    end

    // Register writes in the data phase
    assign mem_wr  = wr_cycle && addr_reg[A_SET_BIT];
    assign int_clr = (wr_cycle && addr_reg == A_INT_CLR) ? hwdata_in[EVW-1:0] : '0;
    assign tgt_rst = wr_cycle && addr_reg == A_TGT_RST && hwdata_in[0];

    always_comb begin
        ctrl_next     = ctrl_reg;
        group_next    = group_reg;
        int_en_next   = int_en_reg;
        tick_div_next = tick_div_reg;
        base_next     = base_reg;
        if (wr_cycle && !addr_reg[A_SET_BIT]) begin
            case (addr_reg)
                A_CTRL:     ctrl_next = hwdata_in[CTRL_W-1:0];
                A_GROUP: begin
                    if (hwdata_in[2:0] < NUM_GROUPS) begin
                        group_next = hwdata_in[2:0];
                    end
                end
                A_INT_EN:   int_en_next = hwdata_in[EVW-1:0];
                A_TICK_DIV: tick_div_next = hwdata_in;
                A_BASE:     base_next = hwdata_in;
                default:    ctrl_next = ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ctrl_reg     <= CTRL_RST;
            group_reg    <= GROUP_RST;
            int_en_reg   <= '0;
            tick_div_reg <= TICK_DIV_RST;
            base_reg     <= BASE_RST;
        end else begin
            ctrl_reg     <= ctrl_next;
            group_reg    <= group_next;
            int_en_reg   <= int_en_next;
            tick_div_reg <= tick_div_next;
            base_reg     <= base_next;
        end
    end

    // Settings come from the active group or the control set only
    assign act_set = ctrl_reg[CTRL_GROUPED] ? group_reg : CONTROL_SET;

    pec_set_mem u_mem (
        .mclk_in    (mclk_in),
        .rst_n_in   (rst_n_in),
        .wr_en_in   (mem_wr),
        .wr_addr_in (addr_reg[MEM_AW+1:2]),
        .wr_data_in (hwdata_in),
        .a_addr_in  (addr_reg[MEM_AW+1:2]),
        .a_data_out (mem_a_data),
        .b_addr_in  ({act_set, scan_reg}),
        .b_data_out (mem_b_data)
    );

    // Larger CT rating is the common base; compare without dividing
    assign base_pu     = (base_reg[BASE_W-1:0] > base_reg[DW-1:BASE_W]) ?
                         base_reg[BASE_W-1:0] : base_reg[DW-1:BASE_W];
    assign meas_scaled = {meas_in, {PU_FRAC{1'b0}}};

    always_comb begin
        scan_next   = scan_reg + 2'h1;
        pk_lo_next  = pk_lo_reg;
        pk_hi_next  = pk_hi_reg;
        pk_dly_next = pk_dly_reg;
        rs_dly_next = rs_dly_reg;
        case (scan_d_reg)
            ITEM_PK_LO:  pk_lo_next = mem_b_data;
            ITEM_PK_HI:  pk_hi_next = mem_b_data;
            ITEM_PK_DLY: pk_dly_next = mem_b_data;
            ITEM_RS_DLY: rs_dly_next = mem_b_data;
            default:     pk_lo_next = pk_lo_reg;
        endcase
        thr_lo_next = pk_lo_reg * base_pu;
        thr_hi_next = pk_hi_reg * base_pu;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            scan_reg   <= '0;
            scan_d_reg <= '0;
            pk_lo_reg  <= '0;
            pk_hi_reg  <= '0;
            pk_dly_reg <= '0;
            rs_dly_reg <= '0;
            thr_lo_reg <= '0;
            thr_hi_reg <= '0;
        end else begin
            scan_reg   <= scan_next;
            scan_d_reg <= scan_reg;
            pk_lo_reg  <= pk_lo_next;
            pk_hi_reg  <= pk_hi_next;
            pk_dly_reg <= pk_dly_next;
            rs_dly_reg <= rs_dly_next;
            thr_lo_reg <= thr_lo_next;
            thr_hi_reg <= thr_hi_next;
        end
    end

    // Run supervision and range test
    assign run = run_in && !block_in && !ctrl_reg[CTRL_BLOCK]
                 && ctrl_reg[CTRL_FUNC];
    assign pk  = run && meas_scaled >= thr_lo_reg && meas_scaled <= thr_hi_reg;

    // Common timebase
    always_comb begin
        tick_next     = tick_cnt_reg >= tick_div_reg;
        tick_cnt_next = tick_next ? '0 : tick_cnt_reg + DW'(1);
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
        end
    end

    pec_delay_timer u_tmr (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .tmr      (tmr_bus.tmr)
    );

    // Element sequencer, outputs, target and events
    always_comb begin
        state_next    = state_reg;
        tmr_bus.start = 1'b0;
        tmr_bus.load  = pk_dly_reg;
        tmr_bus.tick  = tick_reg;
        case (state_reg)
            ST_IDLE: begin
                if (pk) begin
                    if (pk_dly_reg == '0) begin
                        state_next = ST_OPERATE;
                    end else begin
                        tmr_bus.start = 1'b1;
                        state_next    = ST_PICKUP;
                    end
                end
            end
            ST_PICKUP: begin
                if (!pk) begin
                    state_next = ST_IDLE;
                end else if (tmr_bus.done) begin
                    state_next = ST_OPERATE;
                end
            end
            ST_OPERATE: begin
                if (!pk) begin
                    if (rs_dly_reg == '0) begin
                        state_next = ST_IDLE;
                    end else begin
                        tmr_bus.start = 1'b1;
                        tmr_bus.load  = rs_dly_reg;
                        state_next    = ST_RESETTING;
                    end
                end
            end
            ST_RESETTING: begin
                if (pk) begin
                    state_next = ST_OPERATE;
                end else if (tmr_bus.done) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (!run) begin
            state_next    = ST_IDLE;
            tmr_bus.start = 1'b0;
        end
        operate_next = state_next == ST_OPERATE || state_next == ST_RESETTING;
        case (ctrl_reg[CTRL_TGT_LSB +: 2])
            TARGET_FOLLOW_MODE: target_next = operate_next;
            TARGET_LATCHED:     target_next = operate_next || (target_reg && !tgt_rst);
            default:            target_next = 1'b0;
        endcase
        ev_next = '0;
        if (ctrl_reg[CTRL_EVT]) begin
            ev_next[EV_PICKUP]  = pk && !pickup_reg;
            ev_next[EV_DROPOUT] = !pk && pickup_reg;
            ev_next[EV_OPERATE] = operate_next && !operate_reg;
        end
        // Set wins over a same-cycle clear
        int_stat_next = (int_stat_reg & ~int_clr) | ev_next;
        irq_next      = |(int_stat_next & int_en_reg);
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state_reg    <= ST_IDLE;
            pickup_reg   <= 1'b0;
            operate_reg  <= 1'b0;
            target_reg   <= 1'b0;
            ev_reg       <= '0;
            int_stat_reg <= '0;
            irq_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            pickup_reg   <= pk;
            operate_reg  <= operate_next;
            target_reg   <= target_next;
            ev_reg       <= ev_next;
            int_stat_reg <= int_stat_next;
            irq_reg      <= irq_next;
        end
    end

    assign hreadyout_out     = hready_reg;
    assign hresp_out         = HRESP_OKAY;
    assign hrdata_out        = hrdata_reg;
    assign pickup_out        = pickup_reg;
    assign operate_out       = operate_reg;
    assign target_out        = target_reg;
    assign pickup_event_out  = ev_reg[EV_PICKUP];
    assign dropout_event_out = ev_reg[EV_DROPOUT];
    assign operate_event_out = ev_reg[EV_OPERATE];
    assign irq_out           = irq_reg;
endmodule

// file: test/pec_checker.sv
// Port-level assertions for the comparator top.
// Assumes it is bound into pec_top; one clock domain.
`timescale 1ns/1ps
module pec_checker (
    // Watched ports
    input wire logic       mclk_in,
    input wire logic       rst_n_in,
    input wire logic       hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic       hwrite_in,
    input wire logic       hready_in,
    input wire logic       hreadyout_out,
    input wire logic       hresp_out,
    input wire logic       run_in,
    input wire logic       block_in,
    input wire logic       pickup_out,
    input wire logic       operate_out,
    input wire logic       target_out,
    input wire logic       pickup_event_out,
    input wire logic       dropout_event_out,
    input wire logic       operate_event_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    a_run_clears: assert property (!run_in |=> !pickup_out && !operate_out)
        else $error("flags held while run low");
    a_block_inhibit: assert property (block_in |=> !pickup_out && !operate_out)
        else $error("flags held while blocked");
    a_pick_event: assert property (pickup_event_out |-> pickup_out && !$past(pickup_out))
        else $error("pickup event without pickup rise");
    a_drop_event: assert property (dropout_event_out |-> !pickup_out && $past(pickup_out))
        else $error("dropout event without pickup fall");
    a_oper_event: assert property (operate_event_out |-> operate_out && !$past(operate_out))
        else $error("operate event without operate rise");
    a_event_pulse: assert property (pickup_event_out |=> !pickup_event_out)
        else $error("pickup event longer than one cycle");
    a_oper_after_pick: assert property ($rose(operate_out) |-> pickup_out)
        else $error("operate rose outside pickup");
    a_reset_clear: assert property ($rose(rst_n_in) |-> !pickup_out && !operate_out && !target_out)
        else $error("flags set after reset");
    a_read_wait: assert property (hsel_in && htrans_in[1] && !hwrite_in && hready_in
        |=> !hreadyout_out ##1 !hreadyout_out ##1 hreadyout_out)
        else $error("read wait states wrong");
    a_write_nowait: assert property (hsel_in && htrans_in[1] && hwrite_in && hready_in
        |=> hreadyout_out)
        else $error("write stalled");
    a_resp_okay: assert property (hresp_out == 1'b0)
        else $error("response not okay");
endmodule

// file: test/protection_element_comparator_bench.sv
// Self-checking bench for pec_top over AHB-Lite and element pins.
// Assumes pec_pkg constants; tick divider set to 0 to keep runs short.
`timescale 1ns/1ps
module protection_element_comparator_bench;
    import pec_pkg::*;
    logic        clk, rst_n, hsel, hwrite, hrdy, hresp, run, blk, irq;
    logic        rd_pend = 1'b0;
    logic        pk, op, tg, pe, de, oe;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, meas;
    logic [7:0]  rnd;
    logic [31:0] exp_q[$];
    int          err_total, checked;
    pec_top dut (.mclk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
        .meas_in(meas), .run_in(run), .block_in(blk), .pickup_out(pk), .operate_out(op),
        .target_out(tg), .pickup_event_out(pe), .dropout_event_out(de),
        .operate_event_out(oe), .irq_out(irq));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] e);
        checked++;
        if (seen !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, seen);
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Called just after a rising edge; waits on hready, never a fixed count
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (rd_pend && hrdy === 1'b1) begin
            chk("hrdata", hrdata, exp_q.pop_front());
            rd_pend = 1'b0;
        end
        if (hsel && htrans[1] && !hwrite && hrdy) rd_pend = 1'b1;
    end
    initial begin
        tk(20000);
        err_total++;
        wrap_up();
    end
    initial begin
        {rst_n, hsel, hwrite, run, blk} = 5'h00;
        {htrans, hsize, haddr, hwdata, meas} = {2'h0, 3'h2, 64'h0, 32'h0};
        rnd = 8'h3b;
        tk(16);
        rst_n <= 1'b1;
        rd(A_CTRL, 32'h0);
        rd(A_TICK_DIV, TICK_DIV_RST);
        rd(A_BASE, BASE_RST);
        rd(8'h40, 32'h0);
        wr(A_TICK_DIV, 32'h0);
        // Group 0 window far above group 1 so the active group shows
        for (int s = 0; s < 2; s++) begin
            wr(8'(8'h80 + s * 16), (s ? 32'd10 : 32'd100) << 16);
            wr(8'(8'h84 + s * 16), (s ? 32'd20 : 32'd200) << 16);
            wr(8'(8'h88 + s * 16), 32'd20);
            wr(8'(8'h8c + s * 16), 32'd20);
        end
        wr(A_GROUP, 32'h1);
        wr(A_INT_EN, 32'h7);
        rnd = lfsr(rnd);
        meas <= 32'(10 + rnd % 11);
        run <= 1'b1;
        wr(A_CTRL, 32'h2d);
        tk(10);
        rd(A_STATUS, 32'h9);
        tk(40);
        rd(A_STATUS, 32'hf);
        rd(A_INT_STAT, 32'h5);
        meas <= 32'd25;
        rd(A_STATUS, 32'he);
        tk(40);
        rd(A_STATUS, 32'hc);
        rd(A_INT_STAT, 32'h7);
        wr(A_INT_EN, 32'h0);
        tk(2);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(A_INT_EN, 32'h7);
        tk(2);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(A_INT_CLR, 32'h7);
        rd(A_INT_STAT, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(A_TGT_RST, 32'h1);
        rd(A_STATUS, 32'h8);
        wr(A_CTRL, 32'h19);
        meas <= 32'd20;
        tk(50);
        rd(A_STATUS, 32'hf);
        rd(A_INT_STAT, 32'h0);
        meas <= 32'd9;
        tk(50);
        rd(A_STATUS, 32'h8);
        meas <= 32'd15;
        wr(A_GROUP, 32'h0);
        tk(10);
        rd(A_STATUS, 32'h8);
        wr(A_GROUP, 32'h6);
        rd(A_GROUP, 32'h0);
        wr(A_GROUP, 32'h1);
        tk(50);
        run <= 1'b0;
        tk(2);
        rd(A_STATUS, 32'h0);
        run <= 1'b1;
        blk <= 1'b1;
        tk(10);
        rd(A_STATUS, 32'h0);
        blk <= 1'b0;
        wr(A_CTRL, 32'h18);
        tk(10);
        rd(A_STATUS, 32'h0);
        wr(A_CTRL, 32'h09);
        tk(30);
        rd(A_STATUS, 32'hb);
        wr(A_CTRL, 32'h29);
        tk(5);
        rd(A_STATUS, 32'hf);
        // Mid-run reset must drop the latched target too
        rst_n <= 1'b0;
        tk(2);
        rst_n <= 1'b1;
        rd(A_STATUS, 32'h0);
        rd(A_GROUP, 32'h0);
        tk(5);
        wrap_up();
    end
endmodule
bind pec_top pec_checker u_chk (.mclk_in, .rst_n_in, .hsel_in, .htrans_in, .hwrite_in,
    .hready_in, .hreadyout_out, .hresp_out, .run_in, .block_in, .pickup_out, .operate_out,
    .target_out, .pickup_event_out, .dropout_event_out, .operate_event_out);
